// *** hdl/clocked_serial_three_two_wire.sv ***
// serial channel 0: 3-wire and 2-wire clocked serial modes behind APB
// assumes: pins arrive unsynchronised; timer ticks are pclk pulses
`timescale 1ns/1ps
`default_nettype none
`include "serial_ch0_params.svh"

module clocked_serial_three_two_wire (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // internal clock sources, one-cycle pulses on pclk
    input wire logic timer_two_output,
    input wire logic prescaler_tick,
    // serial clock pin
    input wire logic serial_clock_pin_in,
    output logic serial_clock_pin_out,
    output logic serial_clock_pin_oe,
    // 3-wire data pins
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_out_pin_oe,
    // 2-wire open-drain data pins
    input wire logic data_bus_pin_a_in,
    output logic data_bus_pin_a_out,
    output logic data_bus_pin_a_oe,
    input wire logic data_bus_pin_b_in,
    output logic data_bus_pin_b_out,
    output logic data_bus_pin_b_oe,
    // transfer-complete request flag
    output logic transfer_done_flag
);
    import serial_ch0_pkg::*;

    function automatic serial_ch0_pkg::byte_t rev8(
        input serial_ch0_pkg::byte_t d);
        serial_ch0_pkg::byte_t r;
        for (int i = 0; i < 8; i++) begin
            r[i] = d[7-i];
        end
        return r;
    endfunction : rev8

    ////////////////////////////////////////////////////////////////////////
    // state
    byte_t mode;
    byte_t busctl;
    byte_t inttim;
    byte_t shift_register;
    byte_t slave_address_register;
    logic serial_out_latch;
    logic sck_int;
    logic sck_q;
    logic data_q;
    logic [2:0] bit_cnt;
    xfer_state_e state;
    xfer_state_e next_state;
    logic [3:0] pin_level;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation
    pin_sync #(.WIDTH(4)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin({data_bus_pin_b_in, data_bus_pin_a_in,
              serial_in_pin, serial_clock_pin_in}),
        .level(pin_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode
    wire channel_enable = mode[`MODE_EN];
    wire two_wire = mode[`MODE_SEL_HI];
    wire pin_select_a = mode[`MODE_ORDER];
    wire lsb_first = mode[`MODE_ORDER] & ~two_wire;
    wire clock_source_hi = mode[`MODE_CLK_HI];
    wire clock_source_lo = mode[`MODE_CLK_LO];
    wire irq_cause_select = inttim[`TIM_CAUSE];

    wire [`ADDR_W-1:0] a_mode = `ADDR_W'(`IDX_MODE * 4);
    wire [`ADDR_W-1:0] a_busctl = `ADDR_W'(`IDX_BUSCTL * 4);
    wire [`ADDR_W-1:0] a_inttim = `ADDR_W'(`IDX_INTTIM * 4);
    wire [`ADDR_W-1:0] a_shift = `ADDR_W'(`IDX_SHIFT * 4);
    wire [`ADDR_W-1:0] a_sva = `ADDR_W'(`IDX_SVA * 4);
    wire [`ADDR_W-1:0] a_status = `ADDR_W'(`IDX_STATUS * 4);
    wire sel_mode = paddr == a_mode;
    wire sel_busctl = paddr == a_busctl;
    wire sel_inttim = paddr == a_inttim;
    wire sel_shift = paddr == a_shift;
    wire sel_sva = paddr == a_sva;
    wire sel_status = paddr == a_status;
    wire mapped = sel_mode | sel_busctl | sel_inttim | sel_shift
                | sel_sva | sel_status;
    wire access = psel & penable & pready;
    wire wr_lane0 = access & pwrite & pstrb[0] & mapped;
    wire rd = psel & penable & ~pready & ~pwrite;
    wire [7:0] wdata = pwdata[7:0];

    wire wr_mode = wr_lane0 & sel_mode;
    wire wr_busctl = wr_lane0 & sel_busctl;
    wire wr_inttim = wr_lane0 & sel_inttim;
    wire wr_shift = wr_lane0 & sel_shift;
    wire wr_sva = wr_lane0 & sel_sva;
    wire wr_status = wr_lane0 & sel_status;

    ////////////////////////////////////////////////////////////////////////
    // serial clock source and edges
    wire ext_clock = ~clock_source_hi;
    wire src_tick = clock_source_lo ? prescaler_tick
                                    : timer_two_output;
    wire sck_lvl = ext_clock ? pin_level[0] : sck_int;
    wire shifting = state == ST_SHIFT;
    wire int_tick = shifting & ~ext_clock & src_tick;
    wire sck_fall = shifting & (ext_clock ? (sck_q & ~sck_lvl)
                                          : (int_tick & sck_int));
    wire sck_rise = shifting & (ext_clock ? (~sck_q & sck_lvl)
                                          : (int_tick & ~sck_int));
    wire last_bit = sck_rise & (bit_cnt == `BITS_PER_XFER);

    // selected input: 3-wire input pin or the chosen open-drain data pin
    wire data_in = two_wire ? (pin_select_a ? pin_level[2] : pin_level[3])
                            : pin_level[1];
    // stop condition: data rises while the clock is high
    wire stop_seen = channel_enable & two_wire & sck_lvl
                   & data_in & ~data_q;

    // the internal clock must be idle, or an external clock high
    wire start_ok = channel_enable
                  & (ext_clock ? sck_lvl : ~shifting);
    wire start = wr_shift & start_ok;

    wire address_match_flag = channel_enable
        & (slave_address_register == shift_register);
    wire clock_level_status = channel_enable & sck_lvl;

    ////////////////////////////////////////////////////////////////////////
    // transfer sequencing
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (last_bit) begin
                    next_state = ST_END;
                end
            end
            ST_END: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (!channel_enable) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            bit_cnt <= 3'h0;
            sck_q <= 1'b1;
            data_q <= 1'b1;
        end else begin
            state <= next_state;
            sck_q <= sck_lvl;
            data_q <= data_in;
            if (!channel_enable || start) begin
                bit_cnt <= 3'h0;
            end else if (sck_rise) begin
                bit_cnt <= bit_cnt + 3'h1;
            end
        end
    end

    // internal clock idles high and toggles on each selected tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_int <= 1'b1;
        end else if (!shifting) begin
            sck_int <= 1'b1;
        end else if (int_tick) begin
            sck_int <= ~sck_int;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= `REG_RESET;
            busctl <= `REG_RESET;
            inttim <= `REG_RESET;
            slave_address_register <= `REG_RESET;
        end else begin
            if (wr_mode) begin
                mode <= {wdata[7], 1'b0, wdata[5:0]};
            end
            // trigger bits never store; they act once and read zero
            if (wr_busctl) begin
                busctl <= {wdata[7:2], 2'b00};
            end
            if (wr_inttim) begin
                inttim <= {2'b00, wdata[5:0]};
            end
            if (wr_sva) begin
                slave_address_register <= wdata;
            end
        end
    end

    // in lsb-first order both the write and the read are reversed; the shift direction is fixed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_register <= `REG_RESET;
        end else if (wr_shift) begin
            shift_register <= lsb_first ? rev8(wdata) : wdata;
        end else if (sck_rise) begin
            shift_register[0] <= data_in;
        end else if (sck_fall) begin
            shift_register <= {shift_register[6:0], 1'b0};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out_latch <= 1'b1;
        end else if (sck_fall) begin
            serial_out_latch <= shift_register[7];
        end else if (wr_busctl && channel_enable
                     && wdata[`BUS_RELEASE]) begin
            serial_out_latch <= 1'b1;
        end else if (wr_busctl && channel_enable
                     && wdata[`BUS_COMMAND]) begin
            serial_out_latch <= 1'b0;
        end
    end

    // set wins over a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transfer_done_flag <= 1'b0;
        end else if (state == ST_END
                     || (irq_cause_select && stop_seen)) begin
            transfer_done_flag <= 1'b1;
        end else if (wr_status && wdata[`STAT_DONE]) begin
            transfer_done_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins, all registered
    wire next_so_oe = channel_enable & ~two_wire;
    wire next_a_oe = channel_enable & two_wire & pin_select_a
                   & ~serial_out_latch;
    wire next_b_oe = channel_enable & two_wire & ~pin_select_a
                   & ~serial_out_latch;
    wire next_sck_oe = channel_enable & ~ext_clock
                     & (~two_wire | ~sck_int);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out_pin <= 1'b1;
            serial_out_pin_oe <= 1'b0;
            data_bus_pin_a_oe <= 1'b0;
            data_bus_pin_b_oe <= 1'b0;
            serial_clock_pin_out <= 1'b1;
            serial_clock_pin_oe <= 1'b0;
        end else begin
            serial_out_pin <= serial_out_latch;
            serial_out_pin_oe <= next_so_oe;
            data_bus_pin_a_oe <= next_a_oe;
            data_bus_pin_b_oe <= next_b_oe;
            serial_clock_pin_out <= sck_int & ~two_wire;
            serial_clock_pin_oe <= next_sck_oe;
        end
    end

    // open-drain pins only ever pull low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_bus_pin_a_out <= 1'b0;
            data_bus_pin_b_out <= 1'b0;
        end else begin
            data_bus_pin_a_out <= 1'b0;
            data_bus_pin_b_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb answer: one wait state, data and error with pready
    wire [7:0] rd_mode = {mode[7], address_match_flag, mode[5:0]};
    wire [7:0] rd_inttim = {1'b0, clock_level_status, inttim[5:0]};
    wire [7:0] rd_shift = lsb_first ? rev8(shift_register)
                                    : shift_register;
    wire [7:0] rd_byte = sel_mode ? rd_mode
                       : sel_busctl ? busctl
                       : sel_inttim ? rd_inttim
                       : sel_shift ? rd_shift
                       : sel_sva ? slave_address_register
                       : sel_status ? {7'h00, transfer_done_flag}
                       : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            prdata <= rd ? {24'h000000, rd_byte} : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_release_sets_latch: assert property (
        (wr_busctl && channel_enable && wdata[0] && !sck_fall)
        |=> serial_out_latch ##1 serial_out_pin == 1'b1)
        else $error("release write did not raise the output latch");

    a_command_clear_latch: assert property (
        (wr_busctl && channel_enable && !wdata[0] && wdata[1]
         && !sck_fall) |=> !serial_out_latch)
        else $error("command write did not clear the output latch");

    a_eighth_rise_ends: assert property (
        last_bit && channel_enable |=> state == ST_END ##1 transfer_done_flag)
        else $error("transfer did not end after eight bits");

    a_falling_shift: assert property (
        sck_fall |=> serial_out_latch == $past(shift_register[7]))
        else $error("output latch missed the shifted bit");

    a_latch_on_pin: assert property (
        channel_enable && !two_wire && $stable(channel_enable)
        |=> serial_out_pin == $past(serial_out_latch))
        else $error("output pin does not follow the latch");

    a_no_start_idle: assert property (
        wr_shift && !channel_enable |=> state == ST_IDLE [*2])
        else $error("transfer started while disabled");

    a_start_taken: assert property (
        start |=> state == ST_SHIFT && bit_cnt == 3'h0)
        else $error("allowed write did not start a transfer");

    a_abort_clears: assert property (
        !channel_enable |=> state == ST_IDLE && bit_cnt == 3'h0)
        else $error("disable did not abort the transfer");

    a_clock_level_zero: assert property (
        rd && sel_inttim && !channel_enable |=> prdata[6] == 1'b0)
        else $error("clock level read nonzero while disabled");

    c_full_transfer: cover property (start ##[1:1000] state == ST_END);
    c_stop_flag: cover property (irq_cause_select && stop_seen);
    c_lsb_first_write: cover property (wr_shift && lsb_first && start);

endmodule : clocked_serial_three_two_wire

`default_nettype wire

// *** hdl/serial_ch0_params.svh ***
// register indices, field positions, reset values and bus sizes
// assumes: included by the top module and the bench
`ifndef SERIAL_CH0_PARAMS_SVH
`define SERIAL_CH0_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_MODE 16'hff60
`define IDX_BUSCTL 16'hff61
`define IDX_INTTIM 16'hff63
`define IDX_SHIFT 16'hff64
`define IDX_SVA 16'hff65
`define IDX_STATUS 16'hff66
`define ADDR_W 18

// mode register fields
`define MODE_EN 7
`define MODE_MATCH 6
`define MODE_WAKE 5
`define MODE_SEL_HI 4
`define MODE_ORDER 2
`define MODE_CLK_HI 1
`define MODE_CLK_LO 0

// bus control fields
`define BUS_RELEASE 0
`define BUS_COMMAND 1

// interrupt timing fields
`define TIM_CLD 6
`define TIM_CAUSE 5

// status fields
`define STAT_DONE 0

`define REG_RESET 8'h00
`define BITS_PER_XFER 3'h7

`endif

// *** hdl/serial_ch0_pkg.sv ***
// types shared by the serial channel design
// assumes: nothing beyond a SystemVerilog compiler
package serial_ch0_pkg;

    // gray coded along idle -> shift -> end; end -> idle flips both bits
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_END = 2'b11
    } xfer_state_e;

    typedef logic [7:0] byte_t;

endpackage : serial_ch0_pkg

// *** hdl/pin_sync.sv ***
// three-stage synchroniser with agreement filter for asynchronous pins
// assumes: inputs are pins from outside the pclk domain
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // raw pins and filtered levels
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);

    logic [WIDTH-1:0] ff1;
    logic [WIDTH-1:0] ff2;
    logic [WIDTH-1:0] ff3;
    logic [WIDTH-1:0] next_level;

    // a change counts only once the second and third stages agree
    assign next_level = (ff2 & ff3) | (level & (ff2 | ff3));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ff1 <= '1;
            ff2 <= '1;
            ff3 <= '1;
            level <= '1;
        end else begin
            ff1 <= pin;
            ff2 <= ff1;
            ff3 <= ff2;
            level <= next_level;
        end
    end

endmodule : pin_sync

`default_nettype wire

// *** dv/serial_peer.sv ***
// far-side peripheral: clocked serial partner for the 3-wire/2-wire pins
// assumes: the bench resolves the wires; sclk idles high
`timescale 1ns/1ps
`default_nettype none

module serial_peer (
    // serial side
    input wire logic sclk,
    input wire logic sdat,
    // scenario control
    input wire logic restart,
    input wire logic two_wire,
    input wire logic [7:0] tx,
    output logic sin,
    output logic pull_low,
    output logic ext_clk,
    output logic [7:0] rx
);
    logic [2:0] cnt;

    // idle released: no pull on the shared line before the first restart
    initial begin
        ext_clk = 1'b1;
        rx = 8'h00;
        sin = 1'b1;
        cnt = 3'h0;
    end
    // launch on the falling edge so the bit is settled at the rising one
    always @(negedge sclk or posedge restart) begin
        if (restart) begin
            cnt <= 3'h0;
            sin <= 1'b1;
        end else begin
            sin <= tx[3'h7 - cnt];
            cnt <= cnt + 3'h1;
        end
    end
    always @(posedge sclk) rx <= {rx[6:0], sdat};
    // open drain: pull only for a zero
    assign pull_low = two_wire & ~sin;
    // external clock pulses, phase unrelated to pclk
    task automatic clock_out(input int n);
        repeat (n) begin
            ext_clk = 1'b0;
            #97;
            ext_clk = 1'b1;
            #97;
        end
    endtask : clock_out
endmodule : serial_peer
`default_nettype wire

// *** dv/clocked_serial_three_two_wire_tb_top.sv ***
// bench for serial channel 0: apb master, tick sources, pin wiring
// assumes: serial_peer on the pins; pull-ups on every released line
`timescale 1ns/1ps
`default_nettype none
`include "serial_ch0_params.svh"

module clocked_serial_three_two_wire_tb_top;
    logic pclk, presetn, psel, penable, pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic pready, pslverr, timer_two_output, prescaler_tick;
    logic serial_clock_pin_out, serial_clock_pin_oe, serial_in_pin;
    logic serial_out_pin, serial_out_pin_oe, flag;
    logic data_bus_pin_a_out, data_bus_pin_a_oe;
    logic data_bus_pin_b_out, data_bus_pin_b_oe;
    logic restart, two_w, tb_pull, pull_low, ext_clk;
    logic [7:0] ptx, rx;
    logic [1:0] tick_src;
    logic [2:0] div;
    int checked, bad_count;

    ////////////////////////////////////////////////////////////////////
    wire logic sck_w = serial_clock_pin_oe ? serial_clock_pin_out : ext_clk;
    wire logic bus_a = (data_bus_pin_a_oe ? data_bus_pin_a_out : 1'b1)
        & ~pull_low & ~tb_pull;
    wire logic bus_b = data_bus_pin_b_oe ? data_bus_pin_b_out : 1'b1;
    wire logic so_w = serial_out_pin_oe ? serial_out_pin : 1'b1;
    // only the selected open-drain pin may pull, so both lines are anded
    wire logic out_lvl = two_w ? (bus_a & bus_b) : so_w;

    clocked_serial_three_two_wire DUT (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .timer_two_output, .prescaler_tick,
        .serial_clock_pin_in(sck_w), .serial_clock_pin_out,
        .serial_clock_pin_oe, .serial_in_pin, .serial_out_pin,
        .serial_out_pin_oe, .data_bus_pin_a_in(bus_a), .data_bus_pin_a_out,
        .data_bus_pin_a_oe, .data_bus_pin_b_in(bus_b), .data_bus_pin_b_out,
        .data_bus_pin_b_oe, .transfer_done_flag(flag)
    );
    serial_peer peer (
        .sclk(sck_w), .sdat(out_lvl), .restart, .two_wire(two_w),
        .tx(ptx), .sin(serial_in_pin), .pull_low, .ext_clk, .rx
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // only the selected source ticks, so a wrong pick never finishes
    always @(posedge pclk) begin
        div <= div + 3'h1;
        prescaler_tick <= tick_src == 2'b11 && div == 3'h0;
        timer_two_output <= tick_src == 2'b10 && div == 3'h4;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [7:0] s,
            input logic [7:0] e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    task automatic apb(input logic w, input logic [15:0] i,
            input logic [7:0] v, output logic [7:0] d, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, v};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) bad_count++;
        d = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [15:0] i, input logic [7:0] v);
        logic [7:0] d;
        logic e;
        apb(1'b1, i, v, d, e);
    endtask : wr

    task automatic rd(input logic [15:0] i, input string nm,
            input logic [7:0] x);
        logic [7:0] d;
        logic e;
        apb(1'b0, i, 8'h00, d, e);
        check(nm, d, x);
    endtask : rd

    task automatic wait_done();
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (flag !== 1'b1 && n < 3000);
        check("done flag", {7'h0, flag}, 8'h01);
    endtask : wait_done

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] d;
        logic e;
        rd(`IDX_MODE, "mode", 8'h00);
        rd(`IDX_BUSCTL, "busctl", 8'h00);
        rd(`IDX_INTTIM, "inttim", 8'h00);
        apb(1'b0, 16'hff62, 8'h00, d, e);
        check("slverr", {7'h0, e}, 8'h01);
        $display("test reset done");
    endtask : t_reset

    // latch moved only while idle
    task automatic t_latch(input logic [7:0] md);
        two_w <= md[4];
        wr(`IDX_MODE, md);
        wr(`IDX_BUSCTL, 8'h02);
        repeat (2) @(posedge pclk);
        check("latch lo", {7'h0, out_lvl}, 8'h00);
        rd(`IDX_BUSCTL, "busctl", 8'h00);
        wr(`IDX_BUSCTL, 8'h01);
        repeat (2) @(posedge pclk);
        check("latch hi", {7'h0, out_lvl}, 8'h01);
        rd(`IDX_BUSCTL, "busctl", 8'h00);
        $display("test latch %h done", md);
    endtask : t_latch

    // bit order chosen before the data write
    task automatic t_xfer(input logic [7:0] md, d, p, we, re);
        wr(`IDX_MODE, md);
        tick_src <= md[1:0];
        two_w <= md[4];
        ptx <= p;
        restart <= 1'b1;
        @(posedge pclk);
        restart <= 1'b0;
        wr(`IDX_SHIFT, d);
        if (!md[1]) peer.clock_out(8);
        wait_done();
        check("peer rx", rx, we);
        rd(`IDX_SHIFT, "shift rx", re);
        wr(`IDX_STATUS, 8'h01);
        check("flag clr", {7'h0, flag}, 8'h00);
        $display("test xfer %h done", md);
    endtask : t_xfer

    task automatic t_late_en();
        tick_src <= 2'b11;
        wr(`IDX_MODE, 8'h03);
        wr(`IDX_SHIFT, 8'h55);
        wr(`IDX_SVA, 8'h55);
        rd(`IDX_MODE, "match off", 8'h03);
        rd(`IDX_INTTIM, "level off", 8'h00);
        rd(`IDX_SHIFT, "stop reg", 8'h55);
        wr(`IDX_MODE, 8'h83);
        repeat (300) @(posedge pclk);
        check("no start", {7'h0, flag}, 8'h00);
        rd(`IDX_MODE, "match on", 8'hc3);
        wr(`IDX_SVA, 8'h54);
        rd(`IDX_MODE, "match no", 8'h83);
        wr(`IDX_MODE, 8'h80);
        rd(`IDX_INTTIM, "level hi", 8'h40);
        $display("test late enable done");
    endtask : t_late_en

    task automatic t_abort();
        two_w <= 1'b0;
        wr(`IDX_MODE, 8'h83);
        tick_src <= 2'b11;
        wr(`IDX_SHIFT, 8'h00);
        repeat (40) @(posedge pclk);
        wr(`IDX_MODE, 8'h03);
        repeat (200) @(posedge pclk);
        check("abort flag", {7'h0, flag}, 8'h00);
        t_xfer(8'h83, 8'h81, 8'h42, 8'h81, 8'h42);
        $display("test abort done");
    endtask : t_abort

    // wake select and low timing bits kept zero in 2-wire
    task automatic t_stop(input logic [7:0] tim, input logic [7:0] e);
        two_w <= 1'b0;
        wr(`IDX_MODE, 8'h97);
        wr(`IDX_INTTIM, tim);
        wr(`IDX_BUSCTL, 8'h01);
        wr(`IDX_STATUS, 8'h01);
        tb_pull <= 1'b1;
        repeat (8) @(posedge pclk);
        tb_pull <= 1'b0;
        repeat (8) @(posedge pclk);
        check("stop flag", {7'h0, flag}, e);
        wr(`IDX_STATUS, 8'h01);
        $display("test stop %h done", tim);
    endtask : t_stop

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        pstrb = 4'h1;
        {psel, penable, pwrite, restart, two_w, tb_pull} = '0;
        {paddr, pwdata, tick_src, div, ptx} = '0;
        {timer_two_output, prescaler_tick} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_latch(8'h83);
        t_latch(8'h97);
        t_latch(8'h93);
        t_xfer(8'h83, 8'ha5, 8'h3c, 8'ha5, 8'h3c);
        t_xfer(8'h82, 8'h5a, 8'hc6, 8'h5a, 8'hc6);
        t_xfer(8'h87, 8'h1e, 8'h0f, 8'h78, 8'hf0);
        t_xfer(8'h80, 8'hc3, 8'h99, 8'hc3, 8'h99);
        t_xfer(8'h97, 8'h96, 8'hff, 8'h96, 8'h96);
        t_xfer(8'h97, 8'hff, 8'h5a, 8'h5a, 8'h5a);
        t_late_en();
        t_abort();
        t_stop(8'h20, 8'h01);
        t_stop(8'h00, 8'h00);
        give_verdict();
    end

    initial begin
        repeat (30000) @(posedge pclk);
        bad_count++;
        give_verdict();
    end
endmodule : clocked_serial_three_two_wire_tb_top
`default_nettype wire
